// [logic/runtime_misc_pkg.sv]
package runtime_misc_pkg;

  // register byte addresses (offsets 0x21..0x23 are not word aligned: index * 4)
  localparam logic [7:0]  IDX_UART2_FIFO_SHADOW = 8'h21;
  localparam logic [7:0]  IDX_DEVICE_DISABLE    = 8'h22;
  localparam logic [7:0]  IDX_GPIO_BIT_1_0_CTRL = 8'h23;
  localparam logic [11:0] ADDR_UART2_FIFO_SHADOW = {2'h0, IDX_UART2_FIFO_SHADOW, 2'h0};
  localparam logic [11:0] ADDR_DEVICE_DISABLE    = {2'h0, IDX_DEVICE_DISABLE, 2'h0};
  localparam logic [11:0] ADDR_GPIO_BIT_1_0_CTRL = {2'h0, IDX_GPIO_BIT_1_0_CTRL, 2'h0};

  // reset values
  localparam logic [7:0] RST_DEVICE_DISABLE = 8'h00;
  localparam logic [7:0] RST_GPIO_CTRL      = 8'h01;

  // device disable fields
  localparam int DD_FLOPPY_WP  = 0;
  localparam int DD_FLOPPY     = 3;
  localparam int DD_MIDI_UART  = 4;
  localparam int DD_UART2      = 5;
  localparam int DD_UART1      = 6;
  localparam int DD_PARALLEL   = 7;
  localparam logic [7:0] DD_WRITABLE_MASK = 8'hF9;

  // gpio control fields
  localparam int GP_DIR_IN     = 0;
  localparam int GP_INVERT     = 1;
  localparam int GP_ALT_FUNC   = 2;
  localparam int GP_OPEN_DRAIN = 7;
  localparam logic [7:0] GP_WRITABLE_MASK = 8'h87;

  // lock pin configuration value that arms the lock
  localparam logic [1:0] LOCK_CFG_ARMED = 2'b01;

  // second serial port fifo control settings
  typedef struct packed {
    logic [1:0] rx_trigger_level;
    logic       dma_mode;
    logic       tx_fifo_clear;
    logic       rx_fifo_clear;
    logic       fifo_enable;
  } uart_fifo_ctrl_type;

  // per logical device activate / enable set
  typedef struct packed {
    logic parallel_port;
    logic uart1;
    logic uart2;
    logic midi_uart;
    logic floppy_controller;
  } device_set_type;

  // floppy write protect inputs
  typedef struct packed {
    logic drive_select0_n;
    logic drive_select1_n;
    logic force_write_protect;
    logic write_protect_n;
  } floppy_wp_in_type;

endpackage : runtime_misc_pkg

// [logic/runtime_misc_registers.sv]
// Summary of operation
// R1 - offset 0x21 reads uart2 fifo enable, rx clear, tx clear, dma mode; bits 5:4 zero
// R2 - offset 0x21 bits 7:6 hold the uart2 receive trigger level, lsb in bit 6
// R3 - a disable bit at 1 kills its device; at 0 the activate bit rules
// R4 - disable register bit 0 forces floppy write protect over pin and forced bit
// R5 - write protect toward floppy core is or of the four listed terms
// R6 - disable register bits 2:1 always read zero
// R7 - bit 3 disables the floppy controller
// R8 - bit 4 disables the midi uart
// R9 - bit 5 disables the second serial port
// R10 - bit 6 disables the first serial port
// R11 - bit 7 disables the parallel port
// R12 - gpio control bit 0: 1 input, 0 output
// R13 - gpio control bit 1 inverts the pin value both ways
// R14 - gpio control bit 2 routes pin to joystick1 button1; bits 6:3 reserved
// R15 - gpio control bit 7 selects open drain, else push pull
// R16 - disable register is read only when lock config is 01 and lock pin high
// R17 - reset clears disable register and sets gpio control to 0x01
module runtime_misc_registers (
  // apb
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // second serial port fifo settings
  input  wire runtime_misc_pkg::uart_fifo_ctrl_type uart2_fifo_ctrl,
  // lock pin and its configuration
  input  wire logic                                access_lock_pin,
  input  wire logic [1:0]                          access_lock_cfg,
  // logical device activate bits and resulting enables
  input  wire runtime_misc_pkg::device_set_type     device_activate,
  output runtime_misc_pkg::device_set_type          device_enable,
  // floppy write protect
  input  wire runtime_misc_pkg::floppy_wp_in_type   floppy_wp_in,
  output logic                                     write_protect_n,
  // general purpose pin
  input  wire logic                                gpio_bit_1_0_in,
  output logic                                     gpio_bit_1_0_out,
  output logic                                     gpio_bit_1_0_oe,
  // game port side of the pin
  output logic                                     joystick1_button1,
  input  wire logic                                joystick1_button1_drive
);
  import runtime_misc_pkg::*;

  logic [7:0] device_disable_reg;
  logic [7:0] gpio_ctrl_reg;
  logic       access_phase;
  logic       write_strobe;
  logic       read_strobe;
  logic       lock_active;
  logic       mapped;
  logic [7:0] read_byte;
  logic       gpio_level;
  logic       gpio_drive_value;
  logic [7:0] shadow_byte;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] b);
    addr_hit = (a[11:2] == b[11:2]);
  endfunction : addr_hit

  assign access_phase = psel & penable;
  // one wait state per access: the answer is ready in the second access cycle
  assign write_strobe = access_phase & pwrite & pready;
  assign read_strobe  = access_phase & ~pwrite & ~pready;
  assign mapped = addr_hit(paddr, ADDR_UART2_FIFO_SHADOW) |
                  addr_hit(paddr, ADDR_DEVICE_DISABLE) |
                  addr_hit(paddr, ADDR_GPIO_BIT_1_0_CTRL);

  // lock only engages in the armed configuration while the pin is high
  assign lock_active = (access_lock_cfg == LOCK_CFG_ARMED) & access_lock_pin;  // [R16]

  // pready rises one cycle into the access phase, giving registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access_phase & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access_phase & ~pready & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_disable_reg <= RST_DEVICE_DISABLE;  // [R17]
    end else if (write_strobe && pstrb[0] && addr_hit(paddr, ADDR_DEVICE_DISABLE) &&
                 !lock_active) begin  // [R16]
      device_disable_reg <= pwdata[7:0] & DD_WRITABLE_MASK;  // [R6]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_ctrl_reg <= RST_GPIO_CTRL;  // [R17]
    end else if (write_strobe && pstrb[0] && addr_hit(paddr, ADDR_GPIO_BIT_1_0_CTRL)) begin
      gpio_ctrl_reg <= pwdata[7:0] & GP_WRITABLE_MASK;  // [R14]
    end
  end

  // reserved 5:4 forced to zero
  assign shadow_byte = {uart2_fifo_ctrl.rx_trigger_level,  // [R2]
                        2'h0,
                        uart2_fifo_ctrl.dma_mode,
                        uart2_fifo_ctrl.tx_fifo_clear,
                        uart2_fifo_ctrl.rx_fifo_clear,
                        uart2_fifo_ctrl.fifo_enable};  // [R1]

  always_comb begin
    read_byte = 8'h00;
    if (addr_hit(paddr, ADDR_UART2_FIFO_SHADOW)) begin
      read_byte = shadow_byte;  // [R1]
    end else if (addr_hit(paddr, ADDR_DEVICE_DISABLE)) begin
      read_byte = device_disable_reg & DD_WRITABLE_MASK;  // [R6]
    end else if (addr_hit(paddr, ADDR_GPIO_BIT_1_0_CTRL)) begin
      read_byte = gpio_ctrl_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (read_strobe) begin
      prdata <= {24'h00_0000, read_byte};
    end
  end

  // device enables: disable bit wins over activate bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_enable <= '0;
    end else begin
      device_enable.floppy_controller <= device_activate.floppy_controller &
                                         ~device_disable_reg[DD_FLOPPY];  // [R3] [R7]
      device_enable.midi_uart         <= device_activate.midi_uart &
                                         ~device_disable_reg[DD_MIDI_UART];  // [R8]
      device_enable.uart2             <= device_activate.uart2 &
                                         ~device_disable_reg[DD_UART2];  // [R9]
      device_enable.uart1             <= device_activate.uart1 &
                                         ~device_disable_reg[DD_UART1];  // [R10]
      device_enable.parallel_port     <= device_activate.parallel_port &
                                         ~device_disable_reg[DD_PARALLEL];  // [R11]
    end
  end

  // combination kept exactly as the documented active-low equation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_protect_n <= 1'b0;
    end else begin
      write_protect_n <= (floppy_wp_in.drive_select0_n & floppy_wp_in.force_write_protect) |
                         (floppy_wp_in.drive_select1_n & floppy_wp_in.force_write_protect) |
                         floppy_wp_in.write_protect_n |
                         device_disable_reg[DD_FLOPPY_WP];  // [R5] [R4]
    end
  end

  // gpio pin: polarity applies to both directions
  assign gpio_level       = gpio_bit_1_0_in ^ gpio_ctrl_reg[GP_INVERT];  // [R13]
  assign gpio_drive_value = (gpio_ctrl_reg[GP_ALT_FUNC] ? joystick1_button1_drive : 1'b0)
                            ^ gpio_ctrl_reg[GP_INVERT];  // [R13] [R14]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      joystick1_button1 <= 1'b0;
    end else begin
      joystick1_button1 <= gpio_ctrl_reg[GP_ALT_FUNC] & gpio_level;  // [R14]
    end
  end

  // open drain drives only a low level; output data has no gpio data register here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_bit_1_0_out <= 1'b0;
      gpio_bit_1_0_oe  <= 1'b0;
    end else begin
      gpio_bit_1_0_out <= gpio_drive_value;
      if (gpio_ctrl_reg[GP_DIR_IN]) begin
        gpio_bit_1_0_oe <= 1'b0;  // [R12]
      end else if (gpio_ctrl_reg[GP_OPEN_DRAIN]) begin
        gpio_bit_1_0_oe <= ~gpio_drive_value;  // [R15]
      end else begin
        gpio_bit_1_0_oe <= 1'b1;  // [R15]
      end
    end
  end

endmodule : runtime_misc_registers

// [tb/runtime_misc_registers_bench.sv]
module runtime_misc_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import runtime_misc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, write_protect_n, gpio_bit_1_0_out, gpio_bit_1_0_oe;
  logic access_lock_pin = 1'b0, gpio_bit_1_0_in = 1'b1, joystick1_button1;
  logic joystick1_button1_drive = 1'b0;
  logic [1:0] access_lock_cfg = 2'h0;
  uart_fifo_ctrl_type uart2_fifo_ctrl = 6'h00;
  device_set_type device_activate = 5'h1F, device_enable;
  floppy_wp_in_type floppy_wp_in = 4'h0;
  logic [7:0] gp_ctl [7] = '{8'h00, 8'h02, 8'h82, 8'h80, 8'h05, 8'h07, 8'h04};
  logic [2:0] gp_exp [7] = '{3'h1, 3'h3, 3'h0, 3'h1, 3'h4, 3'h0, 3'h7};
  int err_total = 0, checked = 0;
  runtime_misc_registers uut (.*);
  always #25 pclk = ~pclk;
  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // ready is taken at the rising edge that completes the access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    bit got;
    got = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16 && !got; i++) begin
      @(posedge pclk);
      got = (pready === 1'b1);
    end
    if (!got) begin
      err_total++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rc
  // outputs are registered: one edge to load, one more to show
  task automatic settle;
    repeat (2) @(negedge pclk);
  endtask : settle
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc("dis_rst", ADDR_DEVICE_DISABLE, 32'h00);
    rc("gp_rst", ADDR_GPIO_BIT_1_0_CTRL, 32'h01);
    chk("oe_rst", 32'h0, gpio_bit_1_0_oe);
    uart2_fifo_ctrl <= 6'h2B;
    rc("shadow", ADDR_UART2_FIFO_SHADOW, 32'h8B);
    uart2_fifo_ctrl <= 6'h14;
    apb(1'b1, ADDR_UART2_FIFO_SHADOW, 32'hFF);
    rc("shadow2", ADDR_UART2_FIFO_SHADOW, 32'h44);
    apb(1'b0, 12'h090, 32'h0);
    chk("unmapped", 32'h1, er);
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'hFF);
    rc("dis_ff", ADDR_DEVICE_DISABLE, 32'hF9);
    chk("en_off", 32'h0, device_enable);
    for (int b = 3; b < 8; b++) begin
      apb(1'b1, ADDR_DEVICE_DISABLE, 32'h1 << b);
      settle;
      chk("en_one", 5'h1F & ~(5'h1 << (b - 3)), device_enable);
    end
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'h00);
    device_activate <= 5'h15;
    settle;
    chk("en_act", 32'h15, device_enable);
    device_activate <= 5'h1F;
    for (int v = 0; v < 16; v++) begin
      @(posedge pclk);
      floppy_wp_in <= 4'(v);
      settle;
      chk("wp", (v[3] & v[1]) | (v[2] & v[1]) | v[0], write_protect_n);
    end
    floppy_wp_in <= 4'h0;
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'h01);
    settle;
    chk("wp_force", 32'h1, write_protect_n);
    access_lock_cfg <= 2'h1;
    access_lock_pin <= 1'b1;
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'h08);
    rc("locked", ADDR_DEVICE_DISABLE, 32'h01);
    access_lock_pin <= 1'b0;
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'h08);
    rc("unlocked", ADDR_DEVICE_DISABLE, 32'h08);
    access_lock_cfg <= 2'h2;
    access_lock_pin <= 1'b1;
    apb(1'b1, ADDR_DEVICE_DISABLE, 32'h10);
    rc("cfg_other", ADDR_DEVICE_DISABLE, 32'h10);
    apb(1'b1, ADDR_GPIO_BIT_1_0_CTRL, 32'hFF);
    rc("gp_ff", ADDR_GPIO_BIT_1_0_CTRL, 32'h87);
    joystick1_button1_drive <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ADDR_GPIO_BIT_1_0_CTRL, {24'h0, gp_ctl[k]});
      settle;
      chk("joy_oe", {gp_exp[k][2], gp_exp[k][0]}, {joystick1_button1, gpio_bit_1_0_oe});
      if (gp_exp[k][0]) chk("out", gp_exp[k][1], gpio_bit_1_0_out);
    end
    // second reset in mid-run must restore both writable registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc("dis_rst2", ADDR_DEVICE_DISABLE, 32'h00);
    rc("gp_rst2", ADDR_GPIO_BIT_1_0_CTRL, 32'h01);
    final_report;
  end
endmodule : runtime_misc_registers_bench

// [tb/runtime_misc_sva.sv]
module runtime_misc_sva
  import runtime_misc_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sideband
  input wire uart_fifo_ctrl_type uart2_fifo_ctrl,
  input wire device_set_type     device_activate,
  input wire device_set_type     device_enable,
  input wire floppy_wp_in_type   floppy_wp_in,
  input wire logic               write_protect_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_done = psel && penable && pready && !pwrite;
  wire mapped  = paddr inside {ADDR_UART2_FIFO_SHADOW, ADDR_DEVICE_DISABLE,
                               ADDR_GPIO_BIT_1_0_CTRL};
  wire wp_term = floppy_wp_in.force_write_protect &&
                 (floppy_wp_in.drive_select0_n || floppy_wp_in.drive_select1_n);
  sequence s_one_wait; !pready ##1 pready; endsequence
  property p_wait; psel && !penable |=> s_one_wait; endproperty
  property p_idle; !psel |-> !pready; endproperty
  property p_err; pslverr == (pready && !mapped); endproperty
  property p_upper; rd_done |-> prdata[31:8] == 24'h0; endproperty
  property p_shadow; rd_done && paddr == ADDR_UART2_FIFO_SHADOW |->
    prdata[7:0] == {uart2_fifo_ctrl[5:4], 2'h0, uart2_fifo_ctrl[3:0]}; endproperty
  property p_resv; rd_done && paddr == ADDR_DEVICE_DISABLE |-> prdata[2:1] == 2'h0; endproperty
  // an enable may only follow an activate bit seen one edge earlier
  property p_en; (device_enable & ~$past(device_activate)) == 5'h00; endproperty
  property p_wp; floppy_wp_in.write_protect_n || wp_term |=> write_protect_n; endproperty
  a_wait: assert property (p_wait) else $error("ready not in second access cycle");
  a_idle: assert property (p_idle) else $error("ready while not selected");
  a_err: assert property (p_err) else $error("error flag wrong for address");
  a_upper: assert property (p_upper) else $error("upper read data not zero");
  a_shadow: assert property (p_shadow) else $error("fifo shadow mismatch");
  a_resv: assert property (p_resv) else $error("reserved disable bits set");
  a_en: assert property (p_en) else $error("enable without activate");
  a_wp: assert property (p_wp) else $error("write protect term lost");
endmodule : runtime_misc_sva

bind runtime_misc_registers runtime_misc_sva chk (.*);
